// file: rtl/smw_pkg.sv
// smw_pkg: constants shared by the signal module watchdog and alarm logic.
// assumes a single 125 MHz clock and a plain strobe-based host port.
package smw_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_KHZ  = 125000;
  localparam int unsigned WD_TIMEOUT_MS = 3500;
  // longest time, rounds down; exact at 125 MHz
  localparam int unsigned WD_TIMEOUT_CYCLES = WD_TIMEOUT_MS * CLK_FREQ_KHZ;
  localparam int unsigned WD_CNT_W          = 29;

  // ----------------------------------------------------------------
  // decoded window
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W       = 20;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned SW_W         = 8;
  localparam int unsigned IO_SW_LSB    = 4;
  localparam int unsigned MEM_SW_LSB   = 10;
  localparam int unsigned WIN_OFS_W    = 4;
  localparam logic [11:0] MOD1_IO_BASE = 12'h120;

  // offsets inside the 16-byte window
  localparam logic [3:0] OFS_RETRIGGER = 4'h0;
  localparam logic [3:0] OFS_ALARM_ACK = 4'h1;
  localparam logic [3:0] OFS_START     = 4'h2;
  localparam logic [3:0] OFS_EVENT     = 4'h3;
  localparam logic [3:0] OFS_STATUS    = 4'h4;
  localparam logic [3:0] OFS_CONFIG    = 4'h5;

  // status word bit positions
  localparam int unsigned ST_WD_TRIP   = 0;
  localparam int unsigned ST_ALARM     = 1;
  localparam int unsigned ST_BUSY      = 2;
  localparam int unsigned ST_PRESENT   = 3;
  localparam int unsigned ST_START     = 4;

  // config word bit positions (same order as the synchronised option bits)
  localparam int unsigned CF_WD_INV    = 0;
  localparam int unsigned CF_ACK_EXT   = 1;
  localparam int unsigned CF_ALARM_EN  = 2;
  localparam int unsigned CF_WD_EN     = 3;
  localparam int unsigned CF_ALM_BREAK = 4;
  localparam int unsigned CF_PRINTER_PRESENCE_SENSE_SUP  = 5;
  localparam int unsigned CF_MEM_SPACE = 6;
  localparam int unsigned CF_W         = 7;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_RDATA = 8'h00;
  localparam logic       RST_BIT   = 1'b0;

  // watchdog states, gray along run -> trip
  typedef enum logic [1:0] {
    SMW_WD_RUN  = 2'b00,
    SMW_WD_TRIP = 2'b01
  } smw_wd_state_e;

endpackage : smw_pkg

// file: rtl/smw_sync.sv
// smw_sync: two-flop synchroniser for a bundle of slow pin levels.
// assumes each bit is an independent level; no bus coherence is given.
module smw_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             rstn_i,
  // levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // first stage is read only by the second stage
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule // smw_sync

// file: rtl/smw_top.sv
// smw_top: signal module logic: watchdog, alarm latch, hard copy handshake and window decode.
// assumes a host that drives the strobe port on clock_i and static option pins.
//
// Overview of operation
// - the watchdog trips once 3.5 s pass with no retrigger, and each retrigger restarts the timeout.
// - an option inverts the watchdog output, with the normal polarity as default.
// - an option takes the alarm acknowledge from a host write (default) or from an external input.
// - separate options enable the alarm and the watchdog, both enabled by default.
// - an option makes the alarm output assert (default) or deassert on an alarm event.
// - printer presence comes from a cable loopback (default) or a supply level from the printer.
// - the host starts a hard copy through the start output and reads back the printer busy signal.
// - an option selects I/O-space decoding (default) or memory-space decoding.
// - the module answers a contiguous 16-byte window whose base comes from an eight-switch bank.
// - in I/O space the switches compare with address bits 4 to 11, switch 1 on the lowest.
// - in memory space the switches compare with address bits 10 to 17, switch 1 on the lowest.
// - the first signal module sits at I/O base 120H in the standard setup.
// - the general binary inputs and outputs stay inactive.
// - the alarm latches on the first event and ignores later ones until acknowledged.
module smw_top #(
  parameter int unsigned WD_TIMEOUT_CYCLES = smw_pkg::WD_TIMEOUT_CYCLES
) (
  // clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        rstn_i,
  // host port
  input  wire logic [smw_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic                        mem_space_i,
  input  wire logic [smw_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [smw_pkg::DATA_W-1:0]  rdata_o,
  // option jumpers and switches
  input  wire logic                        cfg_wd_invert_i,
  input  wire logic                        cfg_ack_external_i,
  input  wire logic                        cfg_alarm_enable_i,
  input  wire logic                        cfg_wd_enable_i,
  input  wire logic                        cfg_alarm_break_i,
  input  wire logic                        cfg_presence_supply_i,
  input  wire logic                        cfg_mem_space_i,
  input  wire logic [smw_pkg::SW_W-1:0]    base_address_switch_bank_i,
  // field pins
  input  wire logic                        ext_ack_i,
  input  wire logic                        printer_busy_i,
  input  wire logic                        printer_presence_sense_i,
  input  wire logic                        printer_supply_i,
  input  wire logic [2:0]                  bin_in_i,
  output logic                             wd_relay_o,
  output logic                             alarm_relay_o,
  output logic                             hardcopy_start_o,
  output logic [2:0]                       bin_out_o
);

  localparam int unsigned SYNC_W = smw_pkg::CF_W + smw_pkg::SW_W + 4;
  localparam logic [smw_pkg::WD_CNT_W-1:0] WD_LAST = smw_pkg::WD_CNT_W'(WD_TIMEOUT_CYCLES - 1);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0]           sync_q;
  logic [smw_pkg::CF_W-1:0]    cfg;
  logic [smw_pkg::SW_W-1:0]    sw;
  logic                        ack_ext_s;
  logic                        busy_s;
  logic                        printer_presence_sense_loop_s;
  logic                        printer_presence_sense_sup_s;

  // options are static straps, but still cross two flops like any pin
  smw_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .async_i ({printer_supply_i, printer_presence_sense_i, printer_busy_i, ext_ack_i,
               base_address_switch_bank_i, cfg_mem_space_i, cfg_presence_supply_i,
               cfg_alarm_break_i, cfg_wd_enable_i, cfg_alarm_enable_i,
               cfg_ack_external_i, cfg_wd_invert_i}),
    .sync_o  (sync_q)
  );

  assign cfg         = sync_q[smw_pkg::CF_W-1:0];
  assign sw          = sync_q[smw_pkg::CF_W +: smw_pkg::SW_W];
  assign ack_ext_s   = sync_q[SYNC_W-4];
  assign busy_s      = sync_q[SYNC_W-3];
  assign printer_presence_sense_loop_s = sync_q[SYNC_W-2];
  assign printer_presence_sense_sup_s  = sync_q[SYNC_W-1];

  // ----------------------------------------------------------------
  // window decode
  // ----------------------------------------------------------------
  function automatic logic win_hit(input logic [smw_pkg::ADDR_W-1:0] a,
                                   input logic                       mem,
                                   input logic [smw_pkg::CF_W-1:0]   c,
                                   input logic [smw_pkg::SW_W-1:0]   s);
    logic io_ok;
    logic mem_ok;
    io_ok  = (a[smw_pkg::IO_SW_LSB +: smw_pkg::SW_W] == s);
    mem_ok = (a[smw_pkg::MEM_SW_LSB +: smw_pkg::SW_W] == s)
           && (a[smw_pkg::MEM_SW_LSB-1:smw_pkg::IO_SW_LSB] == '0);
    // switch 0x12 puts module 1 at 120H
    if (c[smw_pkg::CF_MEM_SPACE]) begin
      win_hit = mem && mem_ok;
    end else begin
      win_hit = !mem && io_ok;
    end
  endfunction

  logic                          wr_hit;
  logic                          rd_hit;
  logic [smw_pkg::WIN_OFS_W-1:0] ofs;

  assign wr_hit = wr_i && win_hit(addr_i, mem_space_i, cfg, sw);
  assign rd_hit = rd_i && win_hit(addr_i, mem_space_i, cfg, sw);
  assign ofs    = addr_i[smw_pkg::WIN_OFS_W-1:0];

  logic retrig_wr;
  logic ack_wr;
  logic start_wr;
  logic event_wr;

  assign retrig_wr = wr_hit && (ofs == smw_pkg::OFS_RETRIGGER);
  assign ack_wr    = wr_hit && (ofs == smw_pkg::OFS_ALARM_ACK);
  assign start_wr  = wr_hit && (ofs == smw_pkg::OFS_START);
  assign event_wr  = wr_hit && (ofs == smw_pkg::OFS_EVENT);

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  smw_pkg::smw_wd_state_e        wd_state;
  smw_pkg::smw_wd_state_e        next_wd_state;
  logic [smw_pkg::WD_CNT_W-1:0]  wd_cnt;
  logic [smw_pkg::WD_CNT_W-1:0]  next_wd_cnt;
  logic                          wd_tripped;

  assign wd_tripped = (wd_state == smw_pkg::SMW_WD_TRIP);

  // timing starts once the synchronised enable is seen, two cycles after reset release, as if that were the first retrigger
  always_comb begin
    next_wd_state = wd_state;
    next_wd_cnt   = wd_cnt;
    if (!cfg[smw_pkg::CF_WD_EN]) begin
      next_wd_state = smw_pkg::SMW_WD_RUN;
      next_wd_cnt   = '0;
    end else if (retrig_wr) begin
      next_wd_state = smw_pkg::SMW_WD_RUN;
      next_wd_cnt   = '0;
    end else begin
      unique case (wd_state)
        smw_pkg::SMW_WD_RUN: begin
          if (wd_cnt == WD_LAST) begin
            next_wd_state = smw_pkg::SMW_WD_TRIP;
          end else begin
            next_wd_cnt = wd_cnt + 1'b1;
          end
        end
        smw_pkg::SMW_WD_TRIP: begin
          next_wd_state = smw_pkg::SMW_WD_TRIP;
        end
        default: begin
          next_wd_state = smw_pkg::SMW_WD_TRIP;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      wd_state <= smw_pkg::SMW_WD_RUN;
      wd_cnt   <= '0;
    end else begin
      wd_state <= next_wd_state;
      wd_cnt   <= next_wd_cnt;
    end
  end

  // ----------------------------------------------------------------
  // alarm latch
  // ----------------------------------------------------------------
  logic alarm_latched;
  logic next_alarm_latched;
  logic ack_ext_d;
  logic ack_ext_edge;
  logic ack_now;

  assign ack_ext_edge = ack_ext_s && !ack_ext_d;
  assign ack_now      = cfg[smw_pkg::CF_ACK_EXT] ? ack_ext_edge : ack_wr;

  // an event in the acknowledge cycle wins so it is never lost
  always_comb begin
    next_alarm_latched = alarm_latched;
    if (!cfg[smw_pkg::CF_ALARM_EN]) begin
      next_alarm_latched = 1'b0;
    end else if (event_wr) begin
      next_alarm_latched = 1'b1;
    end else if (ack_now) begin
      next_alarm_latched = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      alarm_latched <= smw_pkg::RST_BIT;
      ack_ext_d     <= smw_pkg::RST_BIT;
    end else begin
      alarm_latched <= next_alarm_latched;
      ack_ext_d     <= ack_ext_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs and read data
  // ----------------------------------------------------------------
  logic                         next_wd_relay;
  logic                         next_alarm_relay;
  logic                         next_start;
  logic [smw_pkg::DATA_W-1:0]   next_rdata;
  logic                         present;

  assign present = cfg[smw_pkg::CF_PRINTER_PRESENCE_SENSE_SUP] ? printer_presence_sense_sup_s : printer_presence_sense_loop_s;

  always_comb begin
    next_wd_relay    = wd_tripped ^ cfg[smw_pkg::CF_WD_INV];
    next_alarm_relay = alarm_latched ^ cfg[smw_pkg::CF_ALM_BREAK];
    next_start       = start_wr ? wdata_i[0] : hardcopy_start_o;
    next_rdata       = '0;
    if (rd_hit) begin
      unique case (ofs)
        smw_pkg::OFS_STATUS: begin
          next_rdata[smw_pkg::ST_WD_TRIP] = wd_tripped;
          next_rdata[smw_pkg::ST_ALARM]   = alarm_latched;
          next_rdata[smw_pkg::ST_BUSY]    = busy_s;
          next_rdata[smw_pkg::ST_PRESENT] = present;
          next_rdata[smw_pkg::ST_START]   = hardcopy_start_o;
        end
        smw_pkg::OFS_CONFIG: begin
          next_rdata[smw_pkg::CF_W-1:0] = cfg;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  // binary inputs are sampled nowhere; outputs held off
  always_ff @(posedge clock_i) begin
    if (!rstn_i) begin
      wd_relay_o       <= smw_pkg::RST_BIT;
      alarm_relay_o    <= smw_pkg::RST_BIT;
      hardcopy_start_o <= smw_pkg::RST_BIT;
      rdata_o          <= smw_pkg::RST_RDATA;
      bin_out_o        <= '0;
    end else begin
      wd_relay_o       <= next_wd_relay;
      alarm_relay_o    <= next_alarm_relay;
      hardcopy_start_o <= next_start;
      rdata_o          <= next_rdata;
      bin_out_o        <= '0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  chk_wd_trip_time: assert property (
    (wd_state == smw_pkg::SMW_WD_RUN) && (wd_cnt == WD_LAST) && !retrig_wr && cfg[smw_pkg::CF_WD_EN]
      |=> wd_tripped ##1 (wd_relay_o != cfg[smw_pkg::CF_WD_INV]))
    else $error("watchdog did not trip at timeout");

  chk_wd_retrigger: assert property (
    retrig_wr && cfg[smw_pkg::CF_WD_EN] |=> !wd_tripped && (wd_cnt == '0))
    else $error("retrigger did not restart the watchdog");

  chk_wd_polarity: assert property (
    wd_relay_o == ($past(wd_tripped) ^ $past(cfg[smw_pkg::CF_WD_INV])))
    else $error("watchdog output polarity wrong");

  chk_alarm_hold: assert property (
    alarm_latched && !ack_now && cfg[smw_pkg::CF_ALARM_EN] |=> alarm_latched)
    else $error("alarm latch dropped without acknowledge");

  chk_ack_source: assert property (
    alarm_latched && ack_wr && cfg[smw_pkg::CF_ACK_EXT] && !ack_ext_edge && cfg[smw_pkg::CF_ALARM_EN]
      |=> alarm_latched)
    else $error("bus acknowledge taken while external source selected");

  chk_alarm_enable: assert property (
    !cfg[smw_pkg::CF_ALARM_EN] |=> !alarm_latched)
    else $error("alarm latched while disabled");

  chk_alarm_polarity: assert property (
    event_wr && cfg[smw_pkg::CF_ALARM_EN] && $stable(cfg)
      |=> ##1 (alarm_relay_o == !cfg[smw_pkg::CF_ALM_BREAK]))
    else $error("alarm output wrong after event");

  chk_busy_read: assert property (
    rd_hit && (ofs == smw_pkg::OFS_STATUS) |=> (rdata_o[smw_pkg::ST_BUSY] == $past(busy_s)))
    else $error("busy not returned on status read");

  chk_miss_quiet: assert property (
    !rd_hit |=> (rdata_o == '0))
    else $error("read data outside a window read");

  chk_binary_idle: assert property (
    bin_out_o == '0)
    else $error("binary outputs driven");

endmodule // smw_top

// file: tb/smw_host_model.sv
// smw_host_model: host processor on the expansion bus, driving the strobe port.
// assumes the design samples the port on the rising edge of clock_i.
module smw_host_model (
  // clock
  input  wire logic        clock_i,
  // strobe port
  output logic [19:0]      addr_o,
  output logic             mem_space_o,
  output logic [7:0]       wdata_o,
  output logic             wr_o,
  output logic             rd_o,
  input  wire logic [7:0]  rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  initial begin
    addr_o      = 20'h00000;
    mem_space_o = 1'b0;
    wdata_o     = 8'h00;
    wr_o        = 1'b0;
    rd_o        = 1'b0;
  end

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // released address and data lines show the inverse, so stale values never look valid
  task automatic write(input logic [19:0] a, input logic m, input logic [7:0] dat);
    @(posedge clock_i);
    addr_o      <= a;
    mem_space_o <= m;
    wdata_o     <= dat;
    wr_o        <= 1'b1;
    @(posedge clock_i);
    wr_o        <= 1'b0;
    addr_o      <= ~a;
    wdata_o     <= ~dat;
    // caller looks at outputs only once the sampling edge has settled
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic read(input logic [19:0] a, input logic m, output logic [7:0] d);
    @(posedge clock_i);
    addr_o      <= a;
    mem_space_o <= m;
    rd_o        <= 1'b1;
    @(posedge clock_i);
    rd_o        <= 1'b0;
    addr_o      <= ~a;
    #1 d = rdata_i;
  endtask
endmodule // smw_host_model

// file: tb/testbench.sv
// testbench: self-checking bench for the signal module logic.
// assumes smw_pkg, smw_top and smw_host_model are compiled before it.
`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int unsigned WD_CYC = 50; // short timeout keeps the run brief
  logic        clock_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [19:0] addr;
  logic        mem_space, wr, rd;
  logic [7:0]  wdata, rdata, d;
  logic        cfg_wd_invert = 1'b0, cfg_ack_external = 1'b0, cfg_alarm_enable = 1'b1;
  logic        cfg_wd_enable = 1'b1, cfg_alarm_break = 1'b0, cfg_presence_supply = 1'b0;
  logic        cfg_mem_space = 1'b0;
  logic [7:0]  sw = 8'h12;
  logic        ext_ack = 1'b0, busy = 1'b0, presence = 1'b0, supply = 1'b0;
  logic [2:0]  bin_in = 3'h5;
  logic        wd_relay, alarm_relay, start;
  logic [2:0]  bin_out;
  int          errors = 0;
  int          samples_checked = 0;

  always #4 clock_i = ~clock_i;

  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  smw_host_model smw_host_model_inst (.clock_i(clock_i), .addr_o(addr), .mem_space_o(mem_space),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));

  smw_top #(.WD_TIMEOUT_CYCLES(WD_CYC)) smw_top_inst (.clock_i(clock_i), .rstn_i(rstn_i),
    .addr_i(addr), .mem_space_i(mem_space), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .cfg_wd_invert_i(cfg_wd_invert), .cfg_ack_external_i(cfg_ack_external),
    .cfg_alarm_enable_i(cfg_alarm_enable), .cfg_wd_enable_i(cfg_wd_enable),
    .cfg_alarm_break_i(cfg_alarm_break), .cfg_presence_supply_i(cfg_presence_supply),
    .cfg_mem_space_i(cfg_mem_space), .base_address_switch_bank_i(sw), .ext_ack_i(ext_ack),
    .printer_busy_i(busy), .printer_presence_sense_i(presence), .printer_supply_i(supply),
    .bin_in_i(bin_in), .wd_relay_o(wd_relay), .alarm_relay_o(alarm_relay),
    .hardcopy_start_o(start), .bin_out_o(bin_out));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // switch 1 lands on the lowest compared address bit in both spaces
  function automatic logic [19:0] win(input logic [3:0] ofs);
    win = cfg_mem_space ? {2'h0, sw, 6'h00, ofs} : {8'h00, sw, ofs};
  endfunction

  task automatic wr_ofs(input logic [3:0] ofs, input logic [7:0] v);
    smw_host_model_inst.write(win(ofs), cfg_mem_space, v);
  endtask

  task automatic rd_ofs(input logic [3:0] ofs);
    smw_host_model_inst.read(win(ofs), cfg_mem_space, d);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #(20000 * 8);
    errors++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clock_i);
    rstn_i <= 1'b1;
    #1;
    `CHK("outputs after reset", 6'h00, {wd_relay, alarm_relay, start, bin_out});
    cyc(3);
    // decode
    smw_host_model_inst.read(20'h00125, 1'b0, d);
    `CHK("config at 120H", 8'h0c, d);
    smw_host_model_inst.read(20'h00135, 1'b0, d);
    `CHK("read above window", 8'h00, d);
    smw_host_model_inst.read(20'h00125, 1'b1, d);
    `CHK("memory access in io mode", 8'h00, d);
    @(posedge clock_i) cfg_mem_space <= 1'b1;
    cyc(3);
    smw_host_model_inst.read(20'h04805, 1'b1, d);
    `CHK("config in memory space", 8'h4c, d);
    smw_host_model_inst.read(20'h04815, 1'b1, d);
    `CHK("memory miss on low bits", 8'h00, d);
    smw_host_model_inst.read(20'h00125, 1'b0, d);
    `CHK("io access in memory mode", 8'h00, d);
    @(posedge clock_i) cfg_mem_space <= 1'b0;
    cyc(3);
    $display("test decode done");
    // alarm latch
    wr_ofs(smw_pkg::OFS_EVENT, 8'h00);
    wr_ofs(smw_pkg::OFS_EVENT, 8'h00);
    cyc(2);
    `CHK("alarm after events", 1'b1, alarm_relay);
    wr_ofs(smw_pkg::OFS_ALARM_ACK, 8'h00);
    cyc(2);
    `CHK("alarm after ack", 1'b0, alarm_relay);
    @(posedge clock_i) cfg_alarm_break <= 1'b1;
    cyc(3);
    `CHK("break idle level", 1'b1, alarm_relay);
    wr_ofs(smw_pkg::OFS_EVENT, 8'h00);
    cyc(2);
    `CHK("break on event", 1'b0, alarm_relay);
    @(posedge clock_i) cfg_alarm_break <= 1'b0;
    cfg_ack_external <= 1'b1;
    cyc(3);
    wr_ofs(smw_pkg::OFS_ALARM_ACK, 8'h00);
    cyc(2);
    `CHK("bus ack ignored", 1'b1, alarm_relay);
    @(posedge clock_i) ext_ack <= 1'b1;
    cyc(4);
    @(posedge clock_i) ext_ack <= 1'b0;
    cyc(4);
    `CHK("external ack", 1'b0, alarm_relay);
    @(posedge clock_i) cfg_alarm_enable <= 1'b0;
    cfg_ack_external <= 1'b0;
    cyc(3);
    wr_ofs(smw_pkg::OFS_EVENT, 8'h00);
    cyc(3);
    `CHK("disabled alarm", 1'b0, alarm_relay);
    @(posedge clock_i) cfg_alarm_enable <= 1'b1;
    $display("test alarm done");
    // hard copy
    @(posedge clock_i) busy <= 1'b1;
    presence <= 1'b1;
    wr_ofs(smw_pkg::OFS_START, 8'h01);
    cyc(3);
    `CHK("start output", 1'b1, start);
    rd_ofs(smw_pkg::OFS_STATUS);
    `CHK("start busy presence", 3'h7, d[4:2]);
    @(posedge clock_i) cfg_presence_supply <= 1'b1;
    busy <= 1'b0;
    cyc(3);
    rd_ofs(smw_pkg::OFS_STATUS);
    `CHK("supply source low", 2'h0, d[3:2]);
    @(posedge clock_i) supply <= 1'b1;
    cyc(3);
    rd_ofs(smw_pkg::OFS_STATUS);
    `CHK("supply source high", 1'b1, d[3]);
    wr_ofs(smw_pkg::OFS_START, 8'h00);
    cyc(2);
    `CHK("start cleared", 1'b0, start);
    $display("test hardcopy done");
    // watchdog, tripped WD_CYC cycles after the last retrigger write is sampled, the output one cycle later
    wr_ofs(smw_pkg::OFS_RETRIGGER, 8'h00);
    cyc(2);
    `CHK("retrigger clears trip", 1'b0, wd_relay);
    for (int i = 0; i < 4; i++) begin
      cyc(WD_CYC - 20);
      wr_ofs(smw_pkg::OFS_RETRIGGER, 8'h00);
      `CHK("kept alive", 1'b0, wd_relay);
    end
    cyc(WD_CYC);
    `CHK("before timeout", 1'b0, wd_relay);
    cyc(1);
    `CHK("after timeout", 1'b1, wd_relay);
    rd_ofs(smw_pkg::OFS_STATUS);
    `CHK("trip status", 1'b1, d[0]);
    @(posedge clock_i) cfg_wd_invert <= 1'b1;
    cyc(3);
    `CHK("inverted trip", 1'b0, wd_relay);
    wr_ofs(smw_pkg::OFS_RETRIGGER, 8'h00);
    cyc(2);
    `CHK("inverted running", 1'b1, wd_relay);
    @(posedge clock_i) cfg_wd_enable <= 1'b0;
    cyc(WD_CYC + 20);
    `CHK("disabled watchdog", 1'b1, wd_relay);
    `CHK("binary outputs idle", 3'h0, bin_out);
    $display("test watchdog done");
    stop_test();
  end
endmodule // testbench
